// file: wdtr_watchdog.sv
// Watchdog time-out and reset block with its special function registers.
`timescale 1ns/1ps
`default_nettype none
module wdtr_watchdog import wdtr_pkg::*; (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic wdog_irq,
    output logic wdog_wake,
    output logic cpu_reset
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic [WDTR_CNT_W-1:0] irq_limit(input logic [1:0] sel);
        logic [WDTR_CNT_W-1:0] lim;
        case (sel)
            2'b00: lim = WDTR_ONE << WDTR_EXP0;
            2'b01: lim = WDTR_ONE << WDTR_EXP1;
            2'b10: lim = WDTR_ONE << WDTR_EXP2;
            default: lim = WDTR_ONE << WDTR_EXP3;
        endcase
        return lim;
    endfunction : irq_limit

    function automatic logic hit(input wdtr_sfr_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction : hit

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    wdtr_sfr_req_t req;
    logic unlocked;
    logic [7:0] clk_ctrl_reg;
    logic [7:0] clk_ctrl_next;
    logic [7:0] irq_en_reg;
    logic [7:0] irq_en_next;
    logic rst_en_reg;
    logic rst_en_next;
    logic irq_flag_reg;
    logic irq_flag_next;
    logic rst_flag_reg;
    logic rst_flag_next;
    logic [WDTR_CNT_W-1:0] cnt_reg;
    logic [WDTR_CNT_W-1:0] cnt_next;
    logic tripped_reg;
    logic tripped_next;
    logic [7:0] rdata_next;
    logic irq_next;
    logic wake_next;
    logic cpu_reset_next;
    logic ctrl_wr;
    logic restart;
    logic [1:0] sel;
    logic [WDTR_CNT_W-1:0] lim_irq;
    logic [WDTR_CNT_W-1:0] lim_rst;
    logic at_irq;
    logic at_rst;
    logic fire_irq;
    logic fire_rst;

    assign req = '{wr: sfr_wr, rd: sfr_rd, addr: sfr_addr, wdata: sfr_wdata};

    wdtr_timed_access u_ta (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .req(req),
        .unlocked(unlocked)
    );

    // ------------------------------------------------------------------
    // Request decoding and time-out compare
    // ------------------------------------------------------------------
    assign ctrl_wr = hit(req, WDTR_ADDR_WATCHDOG_CONTROL);
    assign restart = ctrl_wr && unlocked && sfr_wdata[WDTR_RESTART_BIT];
    assign sel = {clk_ctrl_reg[WDTR_SEL_HIGH_BIT], clk_ctrl_reg[WDTR_SEL_LOW_BIT]};
    assign lim_irq = irq_limit(sel);
    assign lim_rst = lim_irq + WDTR_RESET_EXTRA;
    assign at_irq = (cnt_reg == lim_irq - WDTR_ONE);
    // Comparing with at least the last count also ends a period shortened mid-run.
    assign at_rst = (cnt_reg >= lim_rst - WDTR_ONE);
    assign fire_irq = at_irq && !restart;
    assign fire_rst = at_rst && rst_en_reg && !tripped_reg && !restart;

    // Reads of the watchdog control register show the flags and the enable;
    // the restart control always reads as zero.
    function automatic logic [7:0] ctrl_view(input logic irq_f, input logic rst_f,
        input logic en);
        logic [7:0] v;
        v = WDTR_ZERO_BYTE;
        v[WDTR_IRQ_FLAG_BIT] = irq_f;
        v[WDTR_RST_FLAG_BIT] = rst_f;
        v[WDTR_RST_EN_BIT] = en;
        return v;
    endfunction : ctrl_view

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    always_comb begin
        clk_ctrl_next = clk_ctrl_reg;
        irq_en_next = irq_en_reg;
        rst_en_next = rst_en_reg;
        if (hit(req, WDTR_ADDR_CLOCK_SPEED_CONTROL)) begin
            clk_ctrl_next = sfr_wdata;
        end
        if (hit(req, WDTR_ADDR_EXT_IRQ_ENABLE)) begin
            irq_en_next = sfr_wdata;
        end
        if (ctrl_wr && unlocked) begin
            rst_en_next = sfr_wdata[WDTR_RST_EN_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clk_ctrl_reg <= WDTR_CLK_CTRL_RESET;
            irq_en_reg <= WDTR_ZERO_BYTE;
            rst_en_reg <= 1'b0;
        end else begin
            clk_ctrl_reg <= clk_ctrl_next;
            irq_en_reg <= irq_en_next;
            rst_en_reg <= rst_en_next;
        end
    end

    // ------------------------------------------------------------------
    // Time-out counter
    // ------------------------------------------------------------------
    // With reset enabled the counter parks on the reset time-out so that the
    // CPU reset fires once; otherwise it wraps and the interrupt repeats.
    always_comb begin
        cnt_next = cnt_reg + WDTR_ONE;
        tripped_next = tripped_reg;
        if (restart) begin
            cnt_next = '0;
            tripped_next = 1'b0;
        end else if (at_rst && rst_en_reg) begin
            cnt_next = cnt_reg;
            tripped_next = 1'b1;
        end else if (at_rst) begin
            cnt_next = '0;
            tripped_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= '0;
            tripped_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tripped_reg <= tripped_next;
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // A hardware set wins over a software clear in the same cycle.
    always_comb begin
        irq_flag_next = irq_flag_reg;
        rst_flag_next = rst_flag_reg;
        if (ctrl_wr) begin
            irq_flag_next = sfr_wdata[WDTR_IRQ_FLAG_BIT];
            rst_flag_next = sfr_wdata[WDTR_RST_FLAG_BIT];
        end
        if (fire_irq) begin
            irq_flag_next = 1'b1;
        end
        if (fire_rst) begin
            rst_flag_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_flag_reg <= 1'b0;
            rst_flag_reg <= 1'b0;
        end else begin
            irq_flag_reg <= irq_flag_next;
            rst_flag_reg <= rst_flag_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs and read data
    // ------------------------------------------------------------------
    always_comb begin
        irq_next = irq_flag_next && irq_en_next[WDTR_IRQ_EN_BIT];
        wake_next = irq_next;
        cpu_reset_next = fire_rst;
        rdata_next = WDTR_ZERO_BYTE;
        if (sfr_rd) begin
            case (sfr_addr)
                WDTR_ADDR_CLOCK_SPEED_CONTROL: rdata_next = clk_ctrl_reg;
                WDTR_ADDR_EXT_IRQ_ENABLE: rdata_next = irq_en_reg;
                WDTR_ADDR_WATCHDOG_CONTROL: begin
                    rdata_next = ctrl_view(irq_flag_reg, rst_flag_reg, rst_en_reg);
                end
                default: rdata_next = WDTR_ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sfr_rdata <= WDTR_ZERO_BYTE;
            wdog_irq <= 1'b0;
            wdog_wake <= 1'b0;
            cpu_reset <= 1'b0;
        end else begin
            sfr_rdata <= rdata_next;
            wdog_irq <= irq_next;
            wdog_wake <= wake_next;
            cpu_reset <= cpu_reset_next;
        end
    end

endmodule : wdtr_watchdog
`default_nettype wire

// file: wdtr_pkg.sv
// Package of constants and types for the watchdog time-out and reset block.
// Contract
// - Watchdog is a free counter raising a time-out flag; software restarts it anytime.
// - Time-out select comes from clock speed control bits 7 and 6.
// - Interrupt time-out is 2^17, 2^20, 2^23 or 2^26 clocks for codes 0..3.
// - Interrupt flag sets 512 clocks before the reset flag.
// - With reset enabled, reaching reset time-out sets reset flag and resets CPU.
// - Reset enable and restart writes take effect only through timed access unlock.
// - Interrupt reaches CPU only when enabled; enable never affects the reset path.
// - Interrupt serves as periodic time base and can wake the processor.
// - Periods count oscillator clocks directly, exact multiples of the clock period.
// - Controls live in clock speed control, watchdog control D8h, extended enable E8h.
// - Watchdog control: bit 3 irq flag, bit 2 reset flag, bit 1 enable, bit 0 restart.
package wdtr_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] WDTR_ADDR_CLOCK_SPEED_CONTROL = 8'h8e;
    localparam logic [7:0] WDTR_ADDR_WATCHDOG_CONTROL = 8'hd8;
    localparam logic [7:0] WDTR_ADDR_EXT_IRQ_ENABLE = 8'he8;
    localparam logic [7:0] WDTR_ADDR_TIMED_ACCESS = 8'hc7;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int WDTR_SEL_HIGH_BIT = 7;
    localparam int WDTR_SEL_LOW_BIT = 6;
    localparam int WDTR_IRQ_FLAG_BIT = 3;
    localparam int WDTR_RST_FLAG_BIT = 2;
    localparam int WDTR_RST_EN_BIT = 1;
    localparam int WDTR_RESTART_BIT = 0;
    localparam int WDTR_IRQ_EN_BIT = 6;
    localparam logic [7:0] WDTR_CLK_CTRL_RESET = 8'h01;
    localparam logic [7:0] WDTR_ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------------
    // Timed access unlock sequence and window
    // ------------------------------------------------------------------
    localparam logic [7:0] WDTR_TA_KEY1 = 8'haa;
    localparam logic [7:0] WDTR_TA_KEY2 = 8'h55;
    localparam logic [1:0] WDTR_TA_WINDOW = 2'h3;

    // ------------------------------------------------------------------
    // Time-out counts in oscillator clocks
    // ------------------------------------------------------------------
    localparam int WDTR_CNT_W = 27;
    localparam int WDTR_EXP0 = 17;
    localparam int WDTR_EXP1 = 20;
    localparam int WDTR_EXP2 = 23;
    localparam int WDTR_EXP3 = 26;
    localparam logic [WDTR_CNT_W-1:0] WDTR_RESET_EXTRA = 27'h0000200;
    localparam logic [WDTR_CNT_W-1:0] WDTR_ONE = 27'h0000001;

    typedef enum logic [1:0] {
        WDTR_TA_IDLE = 2'b00,
        WDTR_TA_HALF = 2'b01,
        WDTR_TA_OPEN = 2'b10
    } wdtr_ta_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } wdtr_sfr_req_t;

endpackage : wdtr_pkg

// file: wdtr_timed_access.sv
// Timed access unlock sequencer for protected watchdog control bits.
`timescale 1ns/1ps
`default_nettype none
module wdtr_timed_access import wdtr_pkg::*; (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire wdtr_sfr_req_t req,
    output logic unlocked
);

    wdtr_ta_state_t state_reg;
    wdtr_ta_state_t state_next;
    logic [1:0] win_reg;
    logic [1:0] win_next;
    logic ta_wr;

    assign ta_wr = req.wr && (req.addr == WDTR_ADDR_TIMED_ACCESS);
    assign unlocked = (state_reg == WDTR_TA_OPEN);

    // Two key writes open a short window; any protected write closes it.
    always_comb begin
        state_next = state_reg;
        win_next = win_reg;
        case (state_reg)
            WDTR_TA_IDLE: begin
                if (ta_wr && req.wdata == WDTR_TA_KEY1) begin
                    state_next = WDTR_TA_HALF;
                    win_next = WDTR_TA_WINDOW;
                end
            end
            WDTR_TA_HALF: begin
                if (ta_wr && req.wdata == WDTR_TA_KEY2) begin
                    state_next = WDTR_TA_OPEN;
                    win_next = WDTR_TA_WINDOW;
                end else if (win_reg == 2'h0 || ta_wr) begin
                    state_next = WDTR_TA_IDLE;
                end else begin
                    win_next = win_reg - 2'h1;
                end
            end
            WDTR_TA_OPEN: begin
                if (win_reg == 2'h0 || (req.wr && req.addr == WDTR_ADDR_WATCHDOG_CONTROL)) begin
                    state_next = WDTR_TA_IDLE;
                end else begin
                    win_next = win_reg - 2'h1;
                end
            end
            default: begin
                state_next = WDTR_TA_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= WDTR_TA_IDLE;
            win_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            win_reg <= win_next;
        end
    end

endmodule : wdtr_timed_access
`default_nettype wire

// file: wdtr_watchdog_props.sv
// Assertion checker for the watchdog time-out and reset block.
`timescale 1ns/1ps
`default_nettype none
module wdtr_chk import wdtr_pkg::*; (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic wdog_irq,
    input wire logic wdog_wake,
    input wire logic cpu_reset
);
    localparam int RST_MIN = 131583;
    logic key_reg, key_next;
    logic [31:0] age_reg, age_next;
    // Cycles since a restart that followed a key write; can fall below the real count if that key write did not unlock.
    always_comb begin
        key_next = sfr_wr && sfr_addr == WDTR_ADDR_TIMED_ACCESS;
        age_next = age_reg + 32'h1;
        if (key_reg && sfr_wr && sfr_addr == WDTR_ADDR_WATCHDOG_CONTROL && sfr_wdata[0]) begin
            age_next = 32'h0;
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            key_reg <= 1'b0;
            age_reg <= 32'h0;
        end else begin
            key_reg <= key_next;
            age_reg <= age_next;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_unlock;
        sfr_wr && sfr_addr == WDTR_ADDR_TIMED_ACCESS && sfr_wdata == WDTR_TA_KEY1
        ##1 sfr_wr && sfr_addr == WDTR_ADDR_TIMED_ACCESS && sfr_wdata == WDTR_TA_KEY2;
    endsequence
    property p_unlock;
        s_unlock ##1 (sfr_wr && sfr_addr == WDTR_ADDR_WATCHDOG_CONTROL && sfr_wdata[1])
        ##2 (sfr_rd && sfr_addr == WDTR_ADDR_WATCHDOG_CONTROL) |=> sfr_rdata[WDTR_RST_EN_BIT];
    endproperty
    property p_wake; wdog_wake == wdog_irq; endproperty
    property p_idle_rd; !sfr_rd |=> sfr_rdata == 8'h00; endproperty
    property p_unmapped;
        sfr_rd && !(sfr_addr inside {8'h8e, 8'hd8, 8'he8, 8'hc7}) |=> sfr_rdata == 8'h00;
    endproperty
    property p_restart_rd;
        sfr_rd && sfr_addr == WDTR_ADDR_WATCHDOG_CONTROL |=> !sfr_rdata[WDTR_RESTART_BIT];
    endproperty
    property p_rst_pulse; cpu_reset |=> !cpu_reset; endproperty
    property p_rst_min; cpu_reset |-> age_reg >= RST_MIN; endproperty
    property p_irq_off;
        (sfr_wr && sfr_addr == WDTR_ADDR_EXT_IRQ_ENABLE && !sfr_wdata[6]) ##1 !sfr_wr
        |=> !wdog_irq;
    endproperty
    a_unlock: assert property (p_unlock) else $error("reset enable not set after unlock");
    a_wake: assert property (p_wake) else $error("wake differs from irq");
    a_idle_rd: assert property (p_idle_rd) else $error("read data not zero when idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_restart_rd: assert property (p_restart_rd) else $error("restart bit reads one");
    a_rst_pulse: assert property (p_rst_pulse) else $error("cpu reset longer than one cycle");
    a_rst_min: assert property (p_rst_min) else $error("cpu reset too early");
    a_irq_off: assert property (p_irq_off) else $error("irq seen while disabled");
endmodule : wdtr_chk
bind wdtr_watchdog wdtr_chk wdtr_chk_i (.ref_clk(ref_clk), .nrst(nrst), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .wdog_irq(wdog_irq), .wdog_wake(wdog_wake), .cpu_reset(cpu_reset));
`default_nettype wire

// file: wdtr_watchdog_tb_top.sv
// Self-checking testbench for the watchdog time-out and reset block.
`timescale 1ns/1ps
`default_nettype none
module wdtr_watchdog_tb_top import wdtr_pkg::*; ();
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    wdtr_sfr_req_t req = '0;
    logic [7:0] sfr_rdata, d;
    logic wdog_irq, wdog_wake, cpu_reset;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 32'hee479adc;
    int cycles = 0;
    int t0;
    wdtr_watchdog wdtr_watchdog_i (.ref_clk(ref_clk), .nrst(nrst), .sfr_wr(req.wr),
        .sfr_rd(req.rd), .sfr_addr(req.addr), .sfr_wdata(req.wdata), .sfr_rdata(sfr_rdata),
        .wdog_irq(wdog_irq), .wdog_wake(wdog_wake), .cpu_reset(cpu_reset));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic wrap_up();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 140000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, a, v};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 chk(sfr_rdata, exp);
    endtask : rchk
    task automatic unlock(input logic [7:0] v);
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, WDTR_ADDR_TIMED_ACCESS, WDTR_TA_KEY1};
        @(posedge ref_clk);
        req.wdata <= WDTR_TA_KEY2;
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, WDTR_ADDR_WATCHDOG_CONTROL, v};
        @(posedge ref_clk);
        req.wr <= 1'b0;
        #1 t0 = cycles;
    endtask : unlock
    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        rchk(WDTR_ADDR_CLOCK_SPEED_CONTROL, WDTR_CLK_CTRL_RESET);
        rchk(WDTR_ADDR_WATCHDOG_CONTROL, 8'h00);
        rchk(WDTR_ADDR_EXT_IRQ_ENABLE, 8'h00);
        repeat (6) begin
            d = 8'($random(seed));
            wr(WDTR_ADDR_CLOCK_SPEED_CONTROL, d);
            rchk(WDTR_ADDR_CLOCK_SPEED_CONTROL, d);
            d = 8'($random(seed));
            if (!(d inside {8'h8e, 8'hd8, 8'he8, 8'hc7})) rchk(d, 8'h00);
        end
        wr(WDTR_ADDR_WATCHDOG_CONTROL, 8'h03);
        rchk(WDTR_ADDR_WATCHDOG_CONTROL, 8'h00);
        wr(WDTR_ADDR_EXT_IRQ_ENABLE, 8'h40);
        wr(WDTR_ADDR_WATCHDOG_CONTROL, 8'h08);
        repeat (2) @(posedge ref_clk);
        #1 chk({wdog_irq, wdog_wake}, 2'b11);
        wr(WDTR_ADDR_EXT_IRQ_ENABLE, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1 chk(wdog_irq, 1'b0);
        rchk(WDTR_ADDR_WATCHDOG_CONTROL, 8'h08);
        wr(WDTR_ADDR_WATCHDOG_CONTROL, 8'h00);
        wr(WDTR_ADDR_EXT_IRQ_ENABLE, 8'h40);
        unlock(8'h02);
        rchk(WDTR_ADDR_WATCHDOG_CONTROL, 8'h02);
        wr(WDTR_ADDR_CLOCK_SPEED_CONTROL, 8'h00);
        unlock(8'h03);
        // A plain write of the restart bit must not move the time-out.
        repeat (1000) @(posedge ref_clk);
        wr(WDTR_ADDR_WATCHDOG_CONTROL, 8'h03);
        while (wdog_irq !== 1'b1) begin
            @(posedge ref_clk);
            #1;
        end
        chk(cycles - t0 >= 131072 && cycles - t0 <= 131073, 1'b1);
        t0 = cycles;
        while (cpu_reset !== 1'b1) begin
            @(posedge ref_clk);
            #1;
        end
        chk(cycles - t0 >= 511 && cycles - t0 <= 513, 1'b1);
        @(posedge ref_clk);
        #1 chk(cpu_reset, 1'b0);
        rchk(WDTR_ADDR_WATCHDOG_CONTROL, 8'h0e);
        // A second reset in mid-run must clear the flags and the outputs.
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        rchk(WDTR_ADDR_WATCHDOG_CONTROL, 8'h00);
        chk({wdog_irq, wdog_wake, cpu_reset}, 3'b000);
        wrap_up();
    end
endmodule : wdtr_watchdog_tb_top
`default_nettype wire
